// ===== design/pcd_cascade_ctrl.sv
/*
 * Control of the cascaded two-stage clock channel: bandwidth selection,
 * stage bypass, intermediate divider, two even-ratio channel dividers,
 * lock-gated sync and two output drivers, behind an AXI4-Lite slave.
 * Assumes oscillator and reference edges arrive as one-cycle ticks
 * synchronous to clk, and lock and loss-of-reference levels likewise.
 */
`timescale 1ns/1ps
// Function
// - Feedback value picks stage bandwidth setting
// - Separate feedback registers; zero bypasses stage
// - Bypassed stages pass their input straight through
// - Intermediate divider divides first oscillator by field
// - Channel ratio 1 to 16, then divide two
// - Channel divider off with its driver
// - Sync high holds channel dividers reset, clocks blocked
// - Sync falling edge restarts divider clocks
// - Dividers restart from known zero state
// - Sync waits for both stage locks
// - Bit selects first driver 1.8/3.3 V
// - Bit inverts first driver clock
// - Bit powers down first driver alone
// - Loss-of-reference routing ignores first driver bits
// - Four-bit field selects second driver mode
// - Two-bit polarity for second driver CMOS
// - Bit powers down second driver alone
module pcd_cascade_ctrl (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // AXI4-Lite slave
   input  wire logic [pcd_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [pcd_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Analog side: ticks and levels
   input  wire logic                       refScaledTick,
   input  wire logic                       vcoATick,
   input  wire logic                       vcoBTick,
   input  wire logic                       lockA,
   input  wire logic                       lockB,
   input  wire logic                       lostReferenceFlag,
   // Stage control
   output pcd_pkg::pcd_bw_t                bwSelA,
   output pcd_pkg::pcd_bw_t                bwSelB,
   output logic                            bypassA,
   output logic                            bypassB,
   output logic                            pfdBRefTick,
   // Output drivers
   output pcd_pkg::pcd_drv_t               drv
);
   // Register file: staged and active copies
   pcd_pkg::pcd_cfg_t     stgQ, stgD, actQ, actD;
   logic                  awrQ, awrD, bvQ, bvD, arQ, arD, rvQ, rvD;
   logic [1:0]            brQ, brD, rrQ, rrD;
   logic [31:0]           rdQ, rdD;
   logic                  wrHit, rdHit, updPulse;
   logic [9:0]            wIdx, rIdx;
   logic [7:0]            wByte, rVal;
   pcd_pkg::pcd_sync_t    syQ, syD;
   logic                  locked, syncLvl;

   assign wIdx     = s_axi_awaddr[pcd_pkg::ADDR_W-1:2];
   assign rIdx     = s_axi_araddr[pcd_pkg::ADDR_W-1:2];
   assign wrHit    = awrQ && s_axi_awvalid && s_axi_wvalid;
   assign rdHit    = arQ && s_axi_arvalid;
   assign wByte    = s_axi_wdata[7:0];
   assign updPulse = wrHit && s_axi_wstrb[0] && wIdx == pcd_pkg::IDX_UPDATE
                     && wByte[pcd_pkg::UPD_BIT];

   function automatic logic [7:0] readReg(input logic [9:0] idx);
      case (idx)
         pcd_pkg::IDX_UPDATE: readReg = 8'h00;
         pcd_pkg::IDX_CTRL:   readReg = stgQ.ctrl;
         pcd_pkg::IDX_FBDIVA: readReg = stgQ.fbDivA;
         pcd_pkg::IDX_REFDIV: readReg = stgQ.refDiv;
         pcd_pkg::IDX_FBDIVB: readReg = stgQ.fbDivB;
         pcd_pkg::IDX_CHDIV:  readReg = stgQ.chDiv;
         pcd_pkg::IDX_CMOS:   readReg = stgQ.cmosCfg;
         pcd_pkg::IDX_MULTI:  readReg = stgQ.multiCfg;
         pcd_pkg::IDX_LORCFG: readReg = stgQ.lrefCfg;
         pcd_pkg::IDX_STATUS: readReg = {3'h0, syQ != pcd_pkg::SY_RUN, lockB, lockA,
                                         actQ.fbDivB == 8'h00, actQ.fbDivA == 8'h00};
         default:             readReg = 8'h00;
      endcase
   endfunction

   function automatic logic mapped(input logic [9:0] idx);
      mapped = idx == pcd_pkg::IDX_UPDATE || idx == pcd_pkg::IDX_CTRL
            || (idx >= pcd_pkg::IDX_FBDIVA && idx <= pcd_pkg::IDX_CMOS)
            || idx == pcd_pkg::IDX_MULTI || idx == pcd_pkg::IDX_LORCFG
            || idx == pcd_pkg::IDX_STATUS;
   endfunction

   always_comb begin
      stgD = stgQ;
      actD = actQ;
      awrD = s_axi_awvalid && s_axi_wvalid && !awrQ && !bvQ;
      bvD  = bvQ && !s_axi_bready;
      brD  = brQ;
      arD  = s_axi_arvalid && !arQ && !rvQ;
      rvD  = rvQ && !s_axi_rready;
      rrD  = rrQ;
      rdD  = rdQ;
      rVal = readReg(rIdx);
      if (wrHit) begin
         bvD = 1'b1;
         brD = mapped(wIdx) ? pcd_pkg::RESP_OK : pcd_pkg::RESP_ERR;
         if (s_axi_wstrb[0]) begin
            case (wIdx)
               pcd_pkg::IDX_CTRL:   stgD.ctrl     = wByte;
               pcd_pkg::IDX_FBDIVA: stgD.fbDivA   = wByte;
               pcd_pkg::IDX_REFDIV: stgD.refDiv   = wByte;
               pcd_pkg::IDX_FBDIVB: stgD.fbDivB   = wByte;
               pcd_pkg::IDX_CHDIV:  stgD.chDiv    = wByte;
               pcd_pkg::IDX_CMOS:   stgD.cmosCfg  = wByte;
               pcd_pkg::IDX_MULTI:  stgD.multiCfg = wByte;
               pcd_pkg::IDX_LORCFG: stgD.lrefCfg  = wByte;
               default:             stgD = stgQ;
            endcase
         end
      end
      // Copy uses the old staged set; a same-beat write lands next update
      if (updPulse) begin
         actD = stgQ;
      end
      if (rdHit) begin
         rvD = 1'b1;
         rdD = {24'h0, rVal};
         rrD = mapped(rIdx) ? pcd_pkg::RESP_OK : pcd_pkg::RESP_ERR;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stgQ <= '{pcd_pkg::RST_REG, pcd_pkg::RST_FBDV, pcd_pkg::RST_RDIV,
                   pcd_pkg::RST_FBDV, pcd_pkg::RST_REG, pcd_pkg::RST_REG,
                   pcd_pkg::RST_REG, pcd_pkg::RST_REG};
         actQ <= '{pcd_pkg::RST_REG, pcd_pkg::RST_FBDV, pcd_pkg::RST_RDIV,
                   pcd_pkg::RST_FBDV, pcd_pkg::RST_REG, pcd_pkg::RST_REG,
                   pcd_pkg::RST_REG, pcd_pkg::RST_REG};
         awrQ <= 1'b0;
         bvQ  <= 1'b0;
         brQ  <= pcd_pkg::RESP_OK;
         arQ  <= 1'b0;
         rvQ  <= 1'b0;
         rrQ  <= pcd_pkg::RESP_OK;
         rdQ  <= 32'h0000_0000;
      end else begin
         stgQ <= stgD;
         actQ <= actD;
         awrQ <= awrD;
         bvQ  <= bvD;
         brQ  <= brD;
         arQ  <= arD;
         rvQ  <= rvD;
         rrQ  <= rrD;
         rdQ  <= rdD;
      end
   end

   assign s_axi_awready = awrQ;
   assign s_axi_wready  = awrQ;
   assign s_axi_bvalid  = bvQ;
   assign s_axi_bresp   = brQ;
   assign s_axi_arready = arQ;
   assign s_axi_rvalid  = rvQ;
   assign s_axi_rresp   = rrQ;
   assign s_axi_rdata   = rdQ;

   // Sync sequencer and dividers
   logic [7:0]       midCntQ, midCntD;
   logic             midTickQ, midTickD, midSrc, chSrc, lrefRoute;
   logic [1:0][3:0]  cntQ, cntD;
   logic [1:0]       phQ, phD, chPd;

   assign locked   = lockA && lockB;
   assign syncLvl  = actQ.ctrl[pcd_pkg::CTRL_SYNC];
   assign lrefRoute = actQ.lrefCfg[pcd_pkg::LREF_ROUTE];
   assign midSrc   = (actQ.fbDivA == 8'h00) ? refScaledTick : vcoATick;
   assign chSrc    = (actQ.fbDivB == 8'h00) ? midTickQ : vcoBTick;
   assign chPd[0]  = !lrefRoute && actQ.cmosCfg[pcd_pkg::DRV_PD];
   assign chPd[1]  = actQ.multiCfg[pcd_pkg::DRV_PD];

   always_comb begin
      syD = syQ;
      case (syQ)
         pcd_pkg::SY_RUN:  if (syncLvl) syD = pcd_pkg::SY_HOLD;
         pcd_pkg::SY_HOLD: if (!syncLvl) syD = locked ? pcd_pkg::SY_RUN
                                                        : pcd_pkg::SY_WAIT;
         pcd_pkg::SY_WAIT: begin
            if (syncLvl) syD = pcd_pkg::SY_HOLD;
            else if (locked) syD = pcd_pkg::SY_RUN;
         end
         default:          syD = pcd_pkg::SY_RUN;
      endcase
      midCntD  = midCntQ;
      midTickD = 1'b0;
      // Factor 0 and 1 both pass every edge
      if (midSrc) begin
         if (midCntQ + 8'h01 >= actQ.refDiv) begin
            midCntD  = 8'h00;
            midTickD = 1'b1;
         end else begin
            midCntD = midCntQ + 8'h01;
         end
      end
   end

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_chan
         logic [3:0] ratio;
         assign ratio = ch == 0 ? actQ.chDiv[3:0]
                                : actQ.chDiv[pcd_pkg::CHB_LSB+3:pcd_pkg::CHB_LSB];
         always_comb begin
            cntD[ch] = cntQ[ch];
            phD[ch]  = phQ[ch];
            if (syQ != pcd_pkg::SY_RUN || chPd[ch]) begin
               cntD[ch] = 4'h0;
               phD[ch]  = 1'b0;
            end else if (chSrc) begin
               if (cntQ[ch] == ratio) begin
                  cntD[ch] = 4'h0;
                  phD[ch]  = !phQ[ch];
               end else begin
                  cntD[ch] = cntQ[ch] + 4'h1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         syQ      <= pcd_pkg::SY_RUN;
         midCntQ  <= 8'h00;
         midTickQ <= 1'b0;
         cntQ     <= '0;
         phQ      <= 2'b00;
      end else begin
         syQ      <= syD;
         midCntQ  <= midCntD;
         midTickQ <= midTickD;
         cntQ     <= cntD;
         phQ      <= phD;
      end
   end

   // Output drivers and stage controls
   pcd_pkg::pcd_bw_t  bwAQ, bwAD, bwBQ, bwBD;
   pcd_pkg::pcd_drv_t drvQ, drvD;
   logic              byAQ, byAD, byBQ, byBD;
   logic [3:0]        mode;
   logic [1:0]        pol;

   function automatic pcd_pkg::pcd_bw_t bwPick(input logic [7:0] n);
      if (n < pcd_pkg::BW_LOW_LIMIT) bwPick = pcd_pkg::BW_WIDE;
      else if (n <= pcd_pkg::BW_HIGH_LIMIT) bwPick = pcd_pkg::BW_MID;
      else bwPick = pcd_pkg::BW_NARROW;
   endfunction

   assign mode = actQ.multiCfg[pcd_pkg::MM_MODE_LSB+3:pcd_pkg::MM_MODE_LSB];
   assign pol  = actQ.multiCfg[pcd_pkg::MM_POL_LSB+1:pcd_pkg::MM_POL_LSB];

   always_comb begin
      bwAD = bwPick(actQ.fbDivA);
      bwBD = bwPick(actQ.fbDivB);
      byAD = actQ.fbDivA == 8'h00;
      byBD = actQ.fbDivB == 8'h00;
      drvD = '0;
      if (lrefRoute) begin
         // Driver bits ignored: plain 1.8 V, normal sense, powered
         drvD.cmosClk = lostReferenceFlag ^ actQ.lrefCfg[pcd_pkg::LREF_INV];
      end else if (!actQ.cmosCfg[pcd_pkg::DRV_PD]) begin
         drvD.cmos33  = actQ.cmosCfg[pcd_pkg::CMOS_LVL];
         drvD.cmosClk = phQ[0] ^ actQ.cmosCfg[pcd_pkg::CMOS_INV];
      end
      // Undefined codes leave the pins quiet rather than guess a format
      if (!actQ.multiCfg[pcd_pkg::DRV_PD]) begin
         case (mode)
            4'h1, 4'h2: begin
               drvD.multiKind = mode == 4'h1 ? pcd_pkg::MM_HSTL : pcd_pkg::MM_LVDS;
               drvD.multiPos  = phQ[1];
               drvD.multiNeg  = !phQ[1];
            end
            4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE: begin
               drvD.multiKind = pcd_pkg::MM_CMOS;
               drvD.multi33   = mode[3];
               drvD.multiPos  = mode[1:0] != 2'h2 && (phQ[1] ^ pol[1]);
               drvD.multiNeg  = mode[1:0] != 2'h1 && (phQ[1] ^ !pol[0]);
            end
            default: drvD.multiKind = pcd_pkg::MM_OFF;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bwAQ     <= pcd_pkg::BW_MID;
         bwBQ     <= pcd_pkg::BW_MID;
         byAQ     <= 1'b0;
         byBQ     <= 1'b0;
         drvQ     <= '0;
      end else begin
         bwAQ     <= bwAD;
         bwBQ     <= bwBD;
         byAQ     <= byAD;
         byBQ     <= byBD;
         drvQ     <= drvD;
      end
   end

   assign bwSelA      = bwAQ;
   assign bwSelB      = bwBQ;
   assign bypassA     = byAQ;
   assign bypassB     = byBQ;
   assign pfdBRefTick = midTickQ;
   assign drv         = drvQ;

   property p_bw;
      @(posedge clk) disable iff (!rst_n)
      actQ.fbDivA < 8'h18 |=> bwSelA == pcd_pkg::BW_WIDE && $past(actQ.fbDivA) < 8'h18;
   endproperty
   a_bw: assert property (p_bw) else $error("stage A bandwidth wrong");

   property p_bypass;
      @(posedge clk) disable iff (!rst_n)
      actQ.fbDivB == 8'h00 && $stable(actQ.fbDivB) |=> bypassB;
   endproperty
   a_bypass: assert property (p_bypass) else $error("stage B not bypassed");

   property p_update;
      @(posedge clk) disable iff (!rst_n)
      updPulse |=> actQ == $past(stgQ);
   endproperty
   a_update: assert property (p_update) else $error("update did not copy");

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      syncLvl ##1 syncLvl |-> ##1 cntQ == '0 && phQ == 2'b00;
   endproperty
   a_hold: assert property (p_hold) else $error("dividers run during sync");

   property p_release;
      @(posedge clk) disable iff (!rst_n)
      syQ == pcd_pkg::SY_HOLD && !syncLvl && locked |=> syQ == pcd_pkg::SY_RUN;
   endproperty
   a_release: assert property (p_release) else $error("no restart on fall");

   property p_gate;
      @(posedge clk) disable iff (!rst_n)
      syQ == pcd_pkg::SY_WAIT && !locked |=> syQ != pcd_pkg::SY_RUN;
   endproperty
   a_gate: assert property (p_gate) else $error("sync ran before lock");

   property p_lorpin;
      @(posedge clk) disable iff (!rst_n)
      lrefRoute |=> drv.cmosClk == $past(lostReferenceFlag ^ actQ.lrefCfg[pcd_pkg::LREF_INV])
                    && !drv.cmos33;
   endproperty
   a_lorpin: assert property (p_lorpin) else $error("reference flag pin wrong");

   property p_cmospd;
      @(posedge clk) disable iff (!rst_n)
      !lrefRoute && actQ.cmosCfg[pcd_pkg::DRV_PD] |=> !drv.cmosClk && phQ[0] == 1'b0;
   endproperty
   a_cmospd: assert property (p_cmospd) else $error("first driver not down");

   property p_chpd;
      @(posedge clk) disable iff (!rst_n)
      chPd[1] |=> cntQ[1] == 4'h0 && phQ[1] == 1'b0;
   endproperty
   a_chpd: assert property (p_chpd) else $error("second divider runs powered down");

   property p_mmoff;
      @(posedge clk) disable iff (!rst_n)
      mode == 4'h0 |=> !drv.multiPos && !drv.multiNeg && drv.multiKind == pcd_pkg::MM_OFF;
   endproperty
   a_mmoff: assert property (p_mmoff) else $error("second driver not off");
endmodule

// ===== design/pcd_pkg.sv
/*
 * Package for the third-channel cascade clock control: register map,
 * field positions, reset values, state and mode types.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
package pcd_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_UPDATE = 10'h005;
   localparam logic [9:0] IDX_CTRL   = 10'h300;
   localparam logic [9:0] IDX_FBDIVA = 10'h302;
   localparam logic [9:0] IDX_REFDIV = 10'h303;
   localparam logic [9:0] IDX_FBDIVB = 10'h304;
   localparam logic [9:0] IDX_CHDIV  = 10'h305;
   localparam logic [9:0] IDX_CMOS   = 10'h306;
   localparam logic [9:0] IDX_MULTI  = 10'h308;
   localparam logic [9:0] IDX_LORCFG = 10'h309;
   localparam logic [9:0] IDX_STATUS = 10'h30B;
   localparam int ADDR_W = 12;
   // Field positions
   localparam int UPD_BIT      = 0;
   localparam int CTRL_SYNC    = 2;
   localparam int CMOS_LVL     = 3;
   localparam int CMOS_INV     = 1;
   localparam int DRV_PD       = 0;
   localparam int MM_MODE_LSB  = 3;
   localparam int MM_POL_LSB   = 1;
   localparam int LREF_ROUTE   = 0;
   localparam int LREF_INV     = 1;
   localparam int CHB_LSB      = 4;
   // Bandwidth thresholds on the feedback divider value
   localparam logic [7:0] BW_LOW_LIMIT  = 8'h18;
   localparam logic [7:0] BW_HIGH_LIMIT = 8'h2F;
   // Reset values and bus response codes
   localparam logic [7:0] RST_REG  = 8'h00;
   localparam logic [7:0] RST_FBDV = 8'h1E;
   localparam logic [7:0] RST_RDIV = 8'h01;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef enum logic [1:0] {BW_WIDE, BW_MID, BW_NARROW} pcd_bw_t;
   typedef enum logic [1:0] {MM_OFF, MM_HSTL, MM_LVDS, MM_CMOS} pcd_mm_kind_t;
   typedef enum logic [1:0] {SY_RUN, SY_HOLD, SY_WAIT} pcd_sync_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] fbDivA;
      logic [7:0] refDiv;
      logic [7:0] fbDivB;
      logic [7:0] chDiv;
      logic [7:0] cmosCfg;
      logic [7:0] multiCfg;
      logic [7:0] lrefCfg;
   } pcd_cfg_t;

   typedef struct packed {
      logic         cmosClk;
      logic         cmos33;
      logic         multiPos;
      logic         multiNeg;
      logic         multi33;
      pcd_mm_kind_t multiKind;
   } pcd_drv_t;
endpackage

// ===== bench/pcd_clock_sink.sv
/*
 * Downstream clock receiver: counts rising edges of one clock pin and
 * reports the last period, both in clk cycles.
 * Assumes the pin is a registered level synchronous to clk.
 */
`timescale 1ns/1ps
module pcd_clock_sink (
   // Sampling clock
   input  wire logic clk,
   // Received clock pin
   input  wire logic clkIn,
   // Measurements
   output int        edges,
   output int        period
);
   int   gap  = 0;
   logic last = 1'b0;

   // Only rising edges matter to a clocked receiver; duty cycle is not judged
   always @(posedge clk) begin
      last <= clkIn;
      if (clkIn === 1'b1 && last === 1'b0) begin
         edges  <= edges + 1;
         period <= gap + 1;
         gap    <= 0;
      end else begin
         gap <= gap + 1;
      end
   end
endmodule

// ===== bench/pcd_cascade_ctrl_tb.sv
/*
 * Self-checking bench for the cascade clock control: registers over
 * AXI4-Lite, bandwidth, bypass, dividers, sync and both drivers.
 * Assumes oscillator and reference ticks are periodic one-cycle pulses
 * made here, and that pcd_clock_sink measures the clock outputs.
 */
`timescale 1ns/1ps
module pcd_cascade_ctrl_tb;
   typedef struct packed {
      logic [7:0] fb;
      logic [1:0] bw;
      logic [1:0] kind;
      logic       v33;
   } pcd_row_t;
   localparam int LIMIT = 40000;
   logic clk = 0, rst_n = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdData;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic refScaledTick = 0, vcoATick = 0, vcoBTick = 0;
   logic lockA = 1, lockB = 1, lostReferenceFlag = 0;
   logic bypassA, bypassB, pfdBRefTick;
   pcd_pkg::pcd_bw_t  bwSelA, bwSelB;
   pcd_pkg::pcd_drv_t drv;
   int cyc = 0, n_fail = 0, checks_done = 0;
   int eA, pA, eB, pB, eR, pR;
   // Row index is the second driver's mode code
   pcd_row_t rows [16] = '{
      '{8'h00, 2'h0, 2'h0, 1'b0}, '{8'h17, 2'h0, 2'h1, 1'b0}, '{8'h18, 2'h1, 2'h2, 1'b0},
      '{8'h2F, 2'h1, 2'h0, 1'b0}, '{8'h30, 2'h2, 2'h3, 1'b0}, '{8'hFF, 2'h2, 2'h3, 1'b0},
      '{8'h01, 2'h0, 2'h3, 1'b0}, '{8'h1E, 2'h1, 2'h0, 1'b0}, '{8'h00, 2'h0, 2'h0, 1'b0},
      '{8'h17, 2'h0, 2'h0, 1'b0}, '{8'h18, 2'h1, 2'h0, 1'b0}, '{8'h2F, 2'h1, 2'h0, 1'b0},
      '{8'h30, 2'h2, 2'h3, 1'b1}, '{8'h05, 2'h0, 2'h3, 1'b1}, '{8'h80, 2'h2, 2'h3, 1'b1},
      '{8'h00, 2'h0, 2'h0, 1'b0}};

   pcd_cascade_ctrl uut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .refScaledTick,
      .vcoATick, .vcoBTick, .lockA, .lockB, .lostReferenceFlag, .bwSelA, .bwSelB,
      .bypassA, .bypassB, .pfdBRefTick, .drv);
   pcd_clock_sink sinkA (.clk, .clkIn(drv.cmosClk), .edges(eA), .period(pA));
   pcd_clock_sink sinkB (.clk, .clkIn(drv.multiPos), .edges(eB), .period(pB));
   pcd_clock_sink sinkR (.clk, .clkIn(pfdBRefTick), .edges(eR), .period(pR));

   initial begin
      forever #2 clk = ~clk;
   end

   // Fixed tick rates: first oscillator every 2, reference every 4, second every 3
   always @(posedge clk) begin
      cyc           <= cyc + 1;
      vcoATick      <= (cyc % 2 == 0);
      refScaledTick <= (cyc % 4 == 0);
      vcoBTick      <= (cyc % 3 == 0);
      if (cyc == LIMIT) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
   endtask

   task automatic rd(input logic [9:0] idx);
      @(posedge clk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rdData = s_axi_rdata;
      resp   = s_axi_rresp;
   endtask

   // Staged write followed by the update that makes it active
   task automatic set(input logic [9:0] idx, input logic [7:0] d);
      wr(idx, d);
      wr(pcd_pkg::IDX_UPDATE, 8'h01);
      repeat (3) @(posedge clk);
   endtask

   initial begin
      int e0;
      int e1;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("bwSelA", 32'h1, bwSelA);
      rd(pcd_pkg::IDX_FBDIVA);
      chk("fbDivA", 32'h1E, rdData);
      rd(pcd_pkg::IDX_REFDIV);
      chk("refDiv", 32'h01, rdData);
      wr(pcd_pkg::IDX_FBDIVA, 8'h00);
      repeat (3) @(posedge clk);
      chk("bypassA staged", 32'h0, bypassA);
      set(pcd_pkg::IDX_FBDIVA, 8'h00);
      chk("bypassA", 32'h1, bypassA);
      rd(10'h301);
      chk("unmapped rresp", 32'h2, resp);
      chk("unmapped rdata", 32'h0, rdData);
      wr(10'h301, 8'hFF);
      chk("unmapped bresp", 32'h2, resp);
      for (int i = 0; i < 16; i++) begin
         wr(pcd_pkg::IDX_FBDIVA, rows[i].fb);
         wr(pcd_pkg::IDX_FBDIVB, rows[i].fb);
         set(pcd_pkg::IDX_MULTI, {1'b0, i[3:0], 3'b000});
         chk("bwSelA", rows[i].bw, bwSelA);
         chk("bwSelB", rows[i].bw, bwSelB);
         chk("bypassB", rows[i].fb == 8'h00, bypassB);
         chk("multiKind", rows[i].kind, drv.multiKind);
         chk("multi33", rows[i].v33, drv.multi33);
      end
      // Channel A ratio 16, channel B ratio 1, intermediate divides by 3
      wr(pcd_pkg::IDX_FBDIVA, 8'h1E);
      wr(pcd_pkg::IDX_FBDIVB, 8'h1E);
      wr(pcd_pkg::IDX_REFDIV, 8'h03);
      wr(pcd_pkg::IDX_CHDIV, 8'h0F);
      set(pcd_pkg::IDX_MULTI, 8'h20);
      repeat (250) @(posedge clk);
      chk("pfdB period", 32'h6, pR);
      chk("cmos period", 32'h60, pA);
      chk("multi period", 32'h6, pB);
      set(pcd_pkg::IDX_FBDIVA, 8'h00);
      repeat (250) @(posedge clk);
      chk("pfdB bypass", 32'hC, pR);
      chk("bypassA only", 32'h1, {bypassB, bypassA});
      wr(pcd_pkg::IDX_FBDIVA, 8'h1E);
      wr(pcd_pkg::IDX_REFDIV, 8'h01);
      set(pcd_pkg::IDX_FBDIVB, 8'h00);
      repeat (250) @(posedge clk);
      chk("multi bypass", 32'h4, pB);
      chk("cmos bypass", 32'h40, pA);
      // Power-down of one driver must not stop the other
      set(pcd_pkg::IDX_CMOS, 8'h01);
      e0 = eA;
      e1 = eB;
      repeat (100) @(posedge clk);
      chk("cmos stopped", e0, eA);
      chk("multi runs", 32'h1, eB > e1);
      set(pcd_pkg::IDX_CMOS, 8'h00);
      set(pcd_pkg::IDX_MULTI, 8'h21);
      e0 = eA;
      e1 = eB;
      repeat (100) @(posedge clk);
      chk("multi stopped", e1, eB);
      chk("cmos runs", 32'h1, eA > e0);
      set(pcd_pkg::IDX_MULTI, 8'h20);
      set(pcd_pkg::IDX_CTRL, 8'h04);
      e0 = eA;
      repeat (50) @(posedge clk);
      chk("held edges", e0, eA);
      chk("held level", 32'h0, drv.cmosClk);
      rd(pcd_pkg::IDX_STATUS);
      chk("status hold", 32'h1, rdData[4]);
      // Held phase is zero, so pin levels show the polarity setting alone
      for (int p = 0; p < 4; p++) begin
         set(pcd_pkg::IDX_MULTI, 8'h20 | 8'(p << 1));
         chk("multiPos", p[1], drv.multiPos);
         chk("multiNeg", !p[0], drv.multiNeg);
      end
      set(pcd_pkg::IDX_MULTI, 8'h20);
      set(pcd_pkg::IDX_CMOS, 8'h0A);
      chk("cmos inverted", 32'h1, drv.cmosClk);
      chk("cmos33", 32'h1, drv.cmos33);
      set(pcd_pkg::IDX_LORCFG, 8'h01);
      lostReferenceFlag <= 1'b1;
      repeat (3) @(posedge clk);
      chk("lref pin", 32'h1, drv.cmosClk);
      chk("lref 33", 32'h0, drv.cmos33);
      lostReferenceFlag <= 1'b0;
      repeat (3) @(posedge clk);
      chk("lref clear", 32'h0, drv.cmosClk);
      set(pcd_pkg::IDX_LORCFG, 8'h00);
      set(pcd_pkg::IDX_CMOS, 8'h00);
      // Falling sync edge with lockA low must wait for both locks
      lockA <= 1'b0;
      set(pcd_pkg::IDX_CTRL, 8'h00);
      e0 = eA;
      repeat (50) @(posedge clk);
      chk("no lock held", e0, eA);
      lockA <= 1'b1;
      repeat (250) @(posedge clk);
      chk("locked runs", 32'h1, eA > e0);
      chk("restart period", 32'h40, pA);
      set(pcd_pkg::IDX_CTRL, 8'h04);
      set(pcd_pkg::IDX_CTRL, 8'h00);
      rd(pcd_pkg::IDX_STATUS);
      chk("status run", 32'h0, rdData[4]);
      end_of_test();
   end
endmodule
